// >>> rtl/serial_regs_pkg.sv
// shared constants of the synchronous serial port: register map,
// field positions, reset values, engine states and rate decoding.
// assumes a single cpu clock domain using these values.
package serial_regs_pkg;
  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam logic [7:0] OFS_DATA = 8'h21;
  localparam logic [7:0] OFS_CTRL = 8'h22;
  localparam logic [7:0] OFS_STAT = 8'h23;
  localparam logic [7:0] READ_IDLE = 8'h00;
  // ----------------------------------------------------------------
  // serial_control fields
  // ----------------------------------------------------------------
  localparam int CTL_IRQ_EN = 7;
  localparam int CTL_PERIPH_EN = 6;
  localparam int CTL_RATE_DIV = 5;
  localparam int CTL_MASTER = 4;
  localparam int CTL_IDLE_LVL = 3;
  localparam int CTL_CAPT_EDGE = 2;
  localparam int CTL_RATE1 = 1;
  localparam int CTL_RATE0 = 0;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // ----------------------------------------------------------------
  // serial_control_status fields
  // ----------------------------------------------------------------
  localparam int ST_XFER_DONE = 7;
  localparam int ST_WRITE_COLLISION_FLAG = 6;
  localparam int ST_OVR = 5;
  localparam int ST_MODE_FAULT_FLAG = 4;
  localparam int ST_OUT_DIS = 2;
  localparam int ST_SS_SOFT = 1;
  localparam int ST_SS_LVL = 0;
  localparam logic [2:0] STAT_SW_RESET = 3'h0;
  localparam logic [7:0] DATA_RESET = 8'h00;
  // ----------------------------------------------------------------
  // transfer engine
  // ----------------------------------------------------------------
  localparam logic [3:0] LAST_EDGE = 4'hf;
  localparam logic [6:0] HALF_DIV4 = 7'h02;
  localparam logic [6:0] HALF_DIV8 = 7'h04;
  localparam logic [6:0] HALF_DIV16 = 7'h08;
  localparam logic [6:0] HALF_DIV32 = 7'h10;
  localparam logic [6:0] HALF_DIV64 = 7'h20;
  localparam logic [6:0] HALF_DIV128 = 7'h40;
  typedef enum logic [1:0] {
    XS_IDLE = 2'b01,
    XS_RUN = 2'b10
  } xfer_state_t;
  // cpu cycles per half serial clock for rate bits {div, r1, r0}
  function automatic logic [6:0] rate_half(input logic [2:0] sel);
    logic [6:0] h;
    h = HALF_DIV4;
    case (sel)
      3'b100: h = HALF_DIV4;
      3'b000: h = HALF_DIV8;
      3'b001: h = HALF_DIV16;
      3'b110: h = HALF_DIV32;
      3'b010: h = HALF_DIV64;
      3'b011: h = HALF_DIV128;
      default: h = HALF_DIV4;
    endcase
    return h;
  endfunction
endpackage

// >>> rtl/pin_sync_if.sv
// synchronised serial pin levels and clock edge pulses
// assumes producer and consumer share the cpu clock
`timescale 1ns/1ns
`default_nettype none
interface pin_sync_if;
  logic sck_lvl;
  logic sck_rise;
  logic sck_fall;
  logic mosi;
  logic miso;
  logic ss_n;
  modport producer (output sck_lvl, sck_rise, sck_fall, mosi, miso, ss_n);
  modport consumer (input sck_lvl, sck_rise, sck_fall, mosi, miso, ss_n);
endinterface
`default_nettype wire

// >>> rtl/serial_pin_sync.sv
// two-stage synchronisers for the serial pins plus clock edge finder
// assumes the pins are asynchronous to clk_in
`timescale 1ns/1ns
`default_nettype none
module serial_pin_sync (
  // clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // raw pins
  input wire logic sck_in,
  input wire logic mosi_in,
  input wire logic miso_in,
  input wire logic ss_n_in,
  // synchronised side
  pin_sync_if.producer sync_out
);
  logic [3:0] meta_ff;
  logic [3:0] stable_ff;
  logic sck_prev_ff;

  // first stage feeds only the second stage
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      meta_ff <= 4'h0;
      stable_ff <= 4'h0;
      sck_prev_ff <= 1'b0;
    end else begin
      meta_ff <= {ss_n_in, miso_in, mosi_in, sck_in};
      stable_ff <= meta_ff;
      sck_prev_ff <= stable_ff[0];
    end
  end

  // edges come from the settled level only
  assign sync_out.sck_lvl = stable_ff[0];
  assign sync_out.sck_rise = stable_ff[0] & ~sck_prev_ff;
  assign sync_out.sck_fall = ~stable_ff[0] & sck_prev_ff;
  assign sync_out.mosi = stable_ff[1];
  assign sync_out.miso = stable_ff[2];
  assign sync_out.ss_n = stable_ff[3];
endmodule
`default_nettype wire

// >>> rtl/serial_port.sv
// synchronous serial port: registers, flags, shift engine and pins
// assumes a cpu register port on clk_in and a serial partner on pins
//
// Behaviour
// - finished byte sets done flag; interrupt when enabled
// - done flag clears after status read then data read or write
// - data writes ignored while done flag set and status unread
// - data write during a transfer sets the collision flag
// - byte finishing while done flag set raises overrun
// - status read clears the overrun flag
// - select low in master mode sets mode fault, interrupt if enabled
// - mode fault clears after status read then control write
// - output disable releases data output; else drives when enabled
// - soft select management ignores pin, uses internal level bit
// - internal level zero selects slave, one deselects
// - in master mode each data write accepted while idle starts one byte exchange
// - on completion with done flag clear received byte copied into receive buffer
// - data read returns receive buffer, not shift register
// - data write loads shift register directly
// - data, control, status decoded at their addresses with resets
// - mode fault clears enable and master bits by hardware
// - one interrupt for done, mode fault or overrun when enabled
`timescale 1ns/1ns
`default_nettype none
module serial_port
  import serial_regs_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // register port
  input wire logic [serial_regs_pkg::ADDR_W-1:0] addr_in,
  input wire logic [serial_regs_pkg::DATA_W-1:0] wr_data_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  output logic [serial_regs_pkg::DATA_W-1:0] rd_data_out,
  // serial clock pin
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe_out,
  // master-out pin
  input wire logic mosi_in,
  output logic mosi_out,
  output logic mosi_oe_out,
  // slave-out pin
  input wire logic miso_in,
  output logic miso_out,
  output logic miso_oe_out,
  // slave select and interrupt
  input wire logic ss_n_in,
  output logic irq_out
);
  import serial_regs_pkg::*;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  pin_sync_if pins ();
  serial_pin_sync u_sync (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .sck_in(sck_in),
    .mosi_in(mosi_in),
    .miso_in(miso_in),
    .ss_n_in(ss_n_in),
    .sync_out(pins)
  );

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0] ctrl_ff;
  logic [2:0] stat_sw_ff;
  logic xfer_done_flag_ff;
  logic write_collision_flag_ff;
  logic overrun_flag_ff;
  logic mode_fault_flag_ff;
  logic stat_seen_ff;
  logic fault_armed_ff;
  logic [7:0] shreg_ff;
  logic [7:0] rxbuf_ff;
  logic cap_ff;
  logic [3:0] edge_cnt_ff;
  logic [6:0] div_cnt_ff;
  logic sck_lvl_ff;
  logic [7:0] rd_data_ff;
  xfer_state_t state_ff;
  xfer_state_t nxt_state;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire irq_enable = ctrl_ff[CTL_IRQ_EN];
  wire periph_enable = ctrl_ff[CTL_PERIPH_EN];
  wire master_select = ctrl_ff[CTL_MASTER];
  wire idle_level_select = ctrl_ff[CTL_IDLE_LVL];
  wire capture_edge_select = ctrl_ff[CTL_CAPT_EDGE];
  wire output_disable = stat_sw_ff[ST_OUT_DIS];
  wire select_soft_manage = stat_sw_ff[ST_SS_SOFT];
  wire internal_select_level = stat_sw_ff[ST_SS_LVL];
  wire [6:0] half_period = rate_half({ctrl_ff[CTL_RATE_DIV],
                                      ctrl_ff[CTL_RATE1],
                                      ctrl_ff[CTL_RATE0]});
  wire sel_data = (addr_in == OFS_DATA);
  wire sel_ctrl = (addr_in == OFS_CTRL);
  wire sel_stat = (addr_in == OFS_STAT);
  wire data_wr = wr_en_in & sel_data;
  wire data_rd = rd_en_in & sel_data;
  wire data_acc = data_wr | data_rd;
  wire ctrl_wr = wr_en_in & sel_ctrl;
  wire stat_wr = wr_en_in & sel_stat;
  wire stat_rd = rd_en_in & sel_stat;

  // select level seen by the block: pin or internal bit
  wire ss_level = select_soft_manage ? internal_select_level : pins.ss_n;
  wire master_mode = periph_enable & master_select;
  wire slave_sel = periph_enable & ~master_select & ~ss_level;
  wire fault = master_mode & ~ss_level;

  // ----------------------------------------------------------------
  // shift engine edges
  // ----------------------------------------------------------------
  wire running = (state_ff == XS_RUN);
  wire tick = running & (div_cnt_ff == 7'h01);
  wire m_lead = tick & ~edge_cnt_ff[0];
  wire m_trail = tick & edge_cnt_ff[0];
  wire s_lead = slave_sel &
                (idle_level_select ? pins.sck_fall : pins.sck_rise);
  wire s_trail = slave_sel &
                 (idle_level_select ? pins.sck_rise : pins.sck_fall);
  wire lead_ev = master_mode ? m_lead : s_lead;
  wire trail_ev = master_mode ? m_trail : s_trail;
  wire active = master_mode ? running : slave_sel;
  wire busy = master_mode ? running : (slave_sel & (edge_cnt_ff != 4'h0));
  wire din = master_mode ? pins.miso : pins.mosi;
  wire done = trail_ev & (edge_cnt_ff == LAST_EDGE);
  wire in_bit = capture_edge_select ? din : cap_ff;
  wire [7:0] rx_byte = {shreg_ff[6:0], in_bit};

  // data writes blocked until status read while done is set
  wire data_wr_ok = data_wr & ~(xfer_done_flag_ff & ~stat_seen_ff);
  wire load = data_wr_ok & ~busy;
  wire start = load & master_mode;
  wire seq_clear = stat_seen_ff & data_acc;

  // ----------------------------------------------------------------
  // control register, with mode fault override
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ctrl_ff <= CTRL_RESET;
    end else begin
      ctrl_ff <= ctrl_wr ? wr_data_in : ctrl_ff;
      if (fault) begin
        ctrl_ff[CTL_PERIPH_EN] <= 1'b0;
        ctrl_ff[CTL_MASTER] <= 1'b0;
      end
    end
  end

  // software bits of the status register only
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      stat_sw_ff <= STAT_SW_RESET;
    end else if (stat_wr) begin
      stat_sw_ff <= wr_data_in[2:0];
    end
  end

  // ----------------------------------------------------------------
  // flags: a set in the same cycle as a clear wins
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      xfer_done_flag_ff <= 1'b0;
      write_collision_flag_ff <= 1'b0;
      overrun_flag_ff <= 1'b0;
      mode_fault_flag_ff <= 1'b0;
    end else begin
      xfer_done_flag_ff <= done | (xfer_done_flag_ff & ~seq_clear);
      write_collision_flag_ff <= (data_wr_ok & busy) |
                                 (write_collision_flag_ff & ~seq_clear);
      overrun_flag_ff <= (done & xfer_done_flag_ff) |
                         (overrun_flag_ff & ~stat_rd);
      mode_fault_flag_ff <= fault |
                            (mode_fault_flag_ff &
                             ~(fault_armed_ff & ctrl_wr));
    end
  end

  // clear sequence tracking
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      stat_seen_ff <= 1'b0;
      fault_armed_ff <= 1'b0;
    end else begin
      stat_seen_ff <= stat_rd | (stat_seen_ff & ~data_acc);
      fault_armed_ff <= (stat_rd & mode_fault_flag_ff) |
                        (fault_armed_ff & ~ctrl_wr);
    end
  end

  // ----------------------------------------------------------------
  // master sequencer and serial clock generator
  // ----------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      XS_IDLE: nxt_state = start ? XS_RUN : XS_IDLE;
      XS_RUN: nxt_state = (done | ~master_mode) ? XS_IDLE : XS_RUN;
      default: nxt_state = XS_IDLE;
    endcase
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_ff <= XS_IDLE;
      div_cnt_ff <= 7'h01;
      sck_lvl_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      div_cnt_ff <= (start | tick) ? half_period : div_cnt_ff - 7'h01;
      sck_lvl_ff <= running ? (sck_lvl_ff ^ tick) : idle_level_select;
    end
  end

  // ----------------------------------------------------------------
  // shift register, capture bit and edge counter
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      shreg_ff <= DATA_RESET;
      cap_ff <= 1'b0;
    end else begin
      if (load) begin
        shreg_ff <= wr_data_in;
      end else if (lead_ev & capture_edge_select & (edge_cnt_ff != 4'h0)) begin
        shreg_ff <= {shreg_ff[6:0], cap_ff};
      end else if (trail_ev & (~capture_edge_select | done)) begin
        shreg_ff <= rx_byte;
      end
      if ((lead_ev & ~capture_edge_select) |
          (trail_ev & capture_edge_select)) begin
        cap_ff <= din;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      edge_cnt_ff <= 4'h0;
    end else if (~active | start) begin
      edge_cnt_ff <= 4'h0;
    end else if (lead_ev | trail_ev) begin
      edge_cnt_ff <= edge_cnt_ff + 4'h1;
    end
  end

  // receive buffer keeps the unread byte on overrun
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rxbuf_ff <= DATA_RESET;
    end else if (done & ~xfer_done_flag_ff) begin
      rxbuf_ff <= rx_byte;
    end
  end

  // ----------------------------------------------------------------
  // register read port, data one cycle after the strobe
  // ----------------------------------------------------------------
  wire [7:0] stat_view = {xfer_done_flag_ff, write_collision_flag_ff,
                          overrun_flag_ff, mode_fault_flag_ff,
                          1'b0, stat_sw_ff};
  wire [7:0] rd_mux = sel_data ? rxbuf_ff :
                      sel_ctrl ? ctrl_ff :
                      sel_stat ? stat_view : READ_IDLE;

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rd_data_ff <= READ_IDLE;
    end else begin
      rd_data_ff <= rd_en_in ? rd_mux : READ_IDLE;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign rd_data_out = rd_data_ff;
  assign sck_out = sck_lvl_ff;
  assign sck_oe_out = master_mode;
  assign mosi_out = shreg_ff[7];
  assign miso_out = shreg_ff[7];
  assign mosi_oe_out = master_mode & ~output_disable;
  assign miso_oe_out = slave_sel & ~output_disable;
  assign irq_out = irq_enable & (xfer_done_flag_ff | mode_fault_flag_ff |
                                 overrun_flag_ff);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_done_sets;
    @(posedge clk_in) disable iff (!rstn_in)
      done |=> xfer_done_flag_ff;
  endproperty
  a_done_sets: assert property (p_done_sets)
    else $error("done flag not set after completion");
  property p_done_clear;
    @(posedge clk_in) disable iff (!rstn_in)
      $fell(xfer_done_flag_ff) |-> $past(stat_seen_ff & data_acc);
  endproperty
  a_done_clear: assert property (p_done_clear)
    else $error("done flag cleared without sequence");
  property p_write_blocked;
    @(posedge clk_in) disable iff (!rstn_in)
      data_wr & xfer_done_flag_ff & ~stat_seen_ff & ~busy
      |=> $stable(shreg_ff) or (edge_cnt_ff != 4'h0);
  endproperty
  a_write_blocked: assert property (p_write_blocked)
    else $error("blocked data write reached shifter");
  property p_collision;
    @(posedge clk_in) disable iff (!rstn_in)
      data_wr_ok & busy |=> write_collision_flag_ff;
  endproperty
  a_collision: assert property (p_collision)
    else $error("collision not flagged");
  property p_overrun;
    @(posedge clk_in) disable iff (!rstn_in)
      done & xfer_done_flag_ff |=> overrun_flag_ff & $stable(rxbuf_ff);
  endproperty
  a_overrun: assert property (p_overrun)
    else $error("overrun not flagged or buffer lost");
  property p_overrun_clear;
    @(posedge clk_in) disable iff (!rstn_in)
      $fell(overrun_flag_ff) |-> $past(stat_rd);
  endproperty
  a_overrun_clear: assert property (p_overrun_clear)
    else $error("overrun cleared without status read");
  property p_fault;
    @(posedge clk_in) disable iff (!rstn_in)
      fault |=> mode_fault_flag_ff & ~periph_enable & ~master_select;
  endproperty
  a_fault: assert property (p_fault)
    else $error("mode fault did not drop to slave");
  property p_fault_clear;
    @(posedge clk_in) disable iff (!rstn_in)
      $fell(mode_fault_flag_ff) |-> $past(fault_armed_ff & ctrl_wr);
  endproperty
  a_fault_clear: assert property (p_fault_clear)
    else $error("mode fault cleared without sequence");
  property p_out_disable;
    @(posedge clk_in) disable iff (!rstn_in)
      output_disable |-> ~mosi_oe_out & ~miso_oe_out;
  endproperty
  a_out_disable: assert property (p_out_disable)
    else $error("data output driven while disabled");

  property p_read_buffer;
    @(posedge clk_in) disable iff (!rstn_in)
      data_rd |=> rd_data_out == $past(rxbuf_ff);
  endproperty
  a_read_buffer: assert property (p_read_buffer)
    else $error("data read not from receive buffer");
endmodule
`default_nettype wire

// >>> test/serial_slave_model.sv
// serial slave on the far side of the port while it is master
// assumes clock idles low, sample on rise, shift on fall, msb first
`timescale 1ns/1ns
`default_nettype none
module serial_slave_model (
  // serial pins
  input wire logic sck_in,
  input wire logic mosi_in,
  input wire logic sel_n_in,
  output logic miso_out,
  // byte to send and byte received
  input wire logic [7:0] tx_in,
  output logic [7:0] rx_out
);
  logic [7:0] sh;
  logic tog = 1'b0;
  // a released line shows a changing pattern, never a stale bit
  always #3 tog = ~tog;
  assign miso_out = sel_n_in ? tog : sh[7];
  // load on select, sample on rise, shift on fall
  always @(negedge sel_n_in) sh = tx_in;
  always @(posedge sck_in) if (!sel_n_in) rx_out = {rx_out[6:0], mosi_in};
  always @(negedge sck_in) if (!sel_n_in) sh = {sh[6:0], 1'b0};
endmodule
`default_nettype wire

// >>> test/serial_port_test.sv
// self-checking bench for the serial port registers, flags and pins
// assumes one serial port, a slave model and a 250 MHz clock
`timescale 1ns/1ns
`default_nettype none
module serial_port_test;
  import serial_regs_pkg::*;
  // --------
  // signals
  // --------
  logic clk_in, rstn_in, wr_en_in, rd_en_in, ss_n_in, irq_out;
  logic [7:0] addr_in, wr_data_in, rd_data_out, tx_byte, rx_byte, d, got;
  logic sck_out, sck_oe_out, mosi_out, mosi_oe_out, miso_out, miso_oe_out;
  logic m_sck, m_mosi, sel_n, slv_miso;
  logic rd_d = 1'b0;
  logic [7:0] exp_q[$];
  logic [7:0] sv[4] = '{8'h02, 8'h03, 8'h06, 8'h00};
  logic [7:0] ev[4] = '{8'h01, 8'h00, 8'h00, 8'h00};
  logic [31:0] seed;
  int failures, n_compared;
  // wire levels from the port's enables, else the bench or slave model
  wire logic sck_w = sck_oe_out ? sck_out : m_sck;
  wire logic mosi_w = mosi_oe_out ? mosi_out : m_mosi;
  wire logic miso_w = miso_oe_out ? miso_out : slv_miso;
  serial_port u_serial_port (.clk_in(clk_in), .rstn_in(rstn_in),
    .addr_in(addr_in), .wr_data_in(wr_data_in), .wr_en_in(wr_en_in),
    .rd_en_in(rd_en_in), .rd_data_out(rd_data_out), .sck_in(sck_w),
    .sck_out(sck_out), .sck_oe_out(sck_oe_out), .mosi_in(mosi_w),
    .mosi_out(mosi_out), .mosi_oe_out(mosi_oe_out), .miso_in(miso_w),
    .miso_out(miso_out), .miso_oe_out(miso_oe_out), .ss_n_in(ss_n_in),
    .irq_out(irq_out));
  serial_slave_model u_serial_slave_model (.sck_in(sck_w),
    .mosi_in(mosi_w), .sel_n_in(sel_n), .miso_out(slv_miso),
    .tx_in(tx_byte), .rx_out(rx_byte));
  // 4 ns clock
  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end
  // --------
  // helpers
  // --------
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  task automatic wrap_up();
    if (failures == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_in);
    addr_in <= a;
    wr_data_in <= v;
    wr_en_in <= 1'b1;
    @(posedge clk_in);
    wr_en_in <= 1'b0;
  endtask
  // read note goes on the queue before the strobe is taken
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_in);
    addr_in <= a;
    rd_en_in <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk_in);
    rd_en_in <= 1'b0;
  endtask
  task automatic wait_irq(input logic lvl);
    for (int i = 0; i < 2000; i++) begin
      if (irq_out === lvl) break;
      @(posedge clk_in);
    end
    if (irq_out !== lvl) begin
      failures++;
      wrap_up();
    end
  endtask
  // one master byte; col adds a data write while busy
  task automatic mx(input logic [7:0] v, input logic col);
    sel_n = 1'b1;
    tx_byte = rnd();
    #1 sel_n = 1'b0;
    wr(OFS_DATA, v);
    if (col) wr(OFS_DATA, ~v);
    wait_irq(1'b0);
    wait_irq(1'b1);
    check(rx_byte, v);
  endtask
  // bench as link master, 125 ns serial clock; ph samples on second edge
  task automatic send_byte(input logic [7:0] b, input logic ph,
                           output logic [7:0] g);
    for (int i = 7; i >= 0; i--) begin
      if (!ph) m_mosi = b[i];
      #62 m_sck = 1'b1;
      if (ph) m_mosi = b[i];
      else g[i] = miso_w;
      #63 m_sck = 1'b0;
      if (ph) g[i] = miso_w;
    end
    repeat (16) @(posedge clk_in);
  endtask
  // read results come one cycle after the strobe
  always @(posedge clk_in) begin
    rd_d <= rd_en_in;
    if (rd_d === 1'b1) check(rd_data_out, exp_q.pop_front());
  end
  // --------
  // sequence
  // --------
  initial begin
    seed = 32'h6f4e_5a4f;
    failures = 0;
    n_compared = 0;
    rstn_in = 1'b0;
    addr_in = 8'h00;
    wr_data_in = 8'h00;
    wr_en_in = 1'b0;
    rd_en_in = 1'b0;
    ss_n_in = 1'b1;
    m_sck = 1'b0;
    m_mosi = 1'b0;
    sel_n = 1'b1;
    tx_byte = 8'h00;
    repeat (3) @(posedge clk_in);
    rstn_in <= 1'b1;
    // reset values and an unmapped address
    rd(OFS_STAT, 8'h00);
    rd(OFS_CTRL, CTRL_RESET);
    rd(OFS_DATA, DATA_RESET);
    rd(8'h24, READ_IDLE);
    // status writes move only the software bits, bit 3 kept low
    wr(OFS_STAT, 8'hf7);
    rd(OFS_STAT, 8'h07);
    wr(OFS_STAT, 8'h00);
    // master exchange with a collision, then the clear sequence
    wr(OFS_CTRL, 8'hd1);
    @(negedge clk_in);
    check(8'(sck_oe_out & mosi_oe_out), 8'h01);
    mx(rnd(), 1'b1);
    rd(OFS_STAT, 8'hc0);
    rd(OFS_DATA, tx_byte);
    rd(OFS_STAT, 8'h00);
    // data write while done is set and status unread is dropped
    d = rnd();
    mx(d, 1'b0);
    wr(OFS_DATA, 8'h5a);
    repeat (200) @(posedge clk_in);
    check(rx_byte, d);
    rd(OFS_STAT, 8'h80);
    // faster serial rate for the next exchange
    wr(OFS_CTRL, 8'hd0);
    mx(rnd(), 1'b0);
    rd(OFS_STAT, 8'h80);
    rd(OFS_DATA, tx_byte);
    // slave mode: two bytes unread give an overrun
    wr(OFS_CTRL, 8'hc0);
    ss_n_in <= 1'b0;
    // the select pin passes two sync stages first
    repeat (2) @(posedge clk_in);
    @(negedge clk_in);
    check(8'(miso_oe_out), 8'h01);
    d = rnd();
    wr(OFS_DATA, d);
    tx_byte = rnd();
    send_byte(tx_byte, 1'b0, got);
    check(got, d);
    send_byte(rnd(), 1'b0, got);
    rd(OFS_STAT, 8'ha0);
    rd(OFS_DATA, tx_byte);
    rd(OFS_STAT, 8'h00);
    // slave exchange capturing on the second clock edge
    wr(OFS_CTRL, 8'hc4);
    d = rnd();
    wr(OFS_DATA, d);
    tx_byte = rnd();
    send_byte(tx_byte, 1'b1, got);
    check(got, d);
    rd(OFS_STAT, 8'h80);
    rd(OFS_DATA, tx_byte);
    // mode fault in master mode and its clear sequence
    ss_n_in <= 1'b1;
    wr(OFS_CTRL, 8'hd1);
    ss_n_in <= 1'b0;
    wait_irq(1'b1);
    rd(OFS_CTRL, 8'h81);
    @(negedge clk_in);
    check(8'(sck_oe_out), 8'h00);
    wr(OFS_CTRL, 8'h81);
    rd(OFS_STAT, 8'h10);
    wr(OFS_CTRL, 8'h81);
    rd(OFS_STAT, 8'h00);
    // software select management with the pin deselected
    ss_n_in <= 1'b1;
    wr(OFS_CTRL, 8'hc0);
    for (int i = 0; i < 4; i++) begin
      wr(OFS_STAT, sv[i]);
      @(negedge clk_in);
      check(8'(miso_oe_out), ev[i]);
    end
    wr(OFS_CTRL, 8'h00);
    wr(OFS_STAT, 8'h02);
    @(negedge clk_in);
    check(8'(miso_oe_out), 8'h00);
    // pin low is ignored in master mode under software select
    wr(OFS_STAT, 8'h07);
    ss_n_in <= 1'b0;
    wr(OFS_CTRL, 8'hd1);
    @(negedge clk_in);
    check(8'({sck_oe_out, mosi_oe_out}), 8'h02);
    rd(OFS_STAT, 8'h07);
    repeat (2) @(posedge clk_in);
    wrap_up();
  end
endmodule
`default_nettype wire
